// [verilog/bss_seq_regs.vh]
// constants shared by the branch and stack bus-cycle sequencer
`ifndef BSS_SEQ_REGS_VH
`define BSS_SEQ_REGS_VH

// ----------------------------------------
// instruction kinds
// ----------------------------------------
`define BSS_K_BRANCH 3'h0
`define BSS_K_LONG 3'h1
`define BSS_K_HWINT 3'h2
`define BSS_K_PULL 3'h3
`define BSS_K_PUSH 3'h4
`define BSS_K_PEA 3'h5
`define BSS_K_PEI 3'h6
`define BSS_K_PER 3'h7

// ----------------------------------------
// register selectors for pull and push
// ----------------------------------------
`define BSS_R_ACC 3'h0
`define BSS_R_DBANK 3'h1
`define BSS_R_DIR 3'h2
`define BSS_R_STAT 3'h3
`define BSS_R_IDX_X 3'h4
`define BSS_R_IDX_Y 3'h5
`define BSS_R_PBANK 3'h6

// ----------------------------------------
// read-data capture codes
// ----------------------------------------
`define BSS_CAP_NONE 2'h0
`define BSS_CAP_LO 2'h1
`define BSS_CAP_HI 2'h2
`define BSS_CAP_DO 2'h3

// ----------------------------------------
// steps, counts and reset values
// ----------------------------------------
`define BSS_STEP_OPC 4'h1
`define BSS_STEP_2 4'h2
`define BSS_STEP_3 4'h3
`define BSS_STEP_4 4'h4
`define BSS_STEP_5 4'h5
`define BSS_STEP_6 4'h6
`define BSS_STEP_NONE 4'h0
`define BSS_HWINT_WR_NAT 4'h4
`define BSS_HWINT_WR_EMU 4'h3
`define BSS_OPT_MAX 2'h2
`define BSS_INC1 16'h0001
`define BSS_INC2 16'h0002
`define BSS_INC3 16'h0003
`define BSS_BANK_ZERO 8'h00
`define BSS_RST_ADDR 16'h0000
`define BSS_RST_BYTE 8'h00
`define BSS_CYCLE_DIV 4

`endif

// [verilog/bss_cycle_div.v]
// bus-cycle divider: one-cycle pulse at the end of every bus cycle
`timescale 1ns/1ns
`include "bss_seq_regs.vh"
module bss_cycle_div #(
	parameter DIV = `BSS_CYCLE_DIV,
	parameter CW = 8
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	// cycle strobe
	output reg o_tick
);
	reg [CW-1:0] cnt_r;
	wire [CW-1:0] last_w = DIV[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= {CW{1'b0}};
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_r == last_w);
			if (cnt_r == last_w) begin
				cnt_r <= {CW{1'b0}};
			end else begin
				cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // bss_cycle_div

// [verilog/bss_seq.v]
// bus-cycle sequencer for branches, hardware interrupt entry and stack instructions
// Behaviour
// R1 - nine short branches take 2-4 cycles; offset fetched cycle 2 as program read
// R2 - short branch: up to two internal cycles at counter+1, then fetch at target
// R3 - long branch: offset low, high, one internal cycle, fetch at counter plus offset
// R4 - interrupt entry: two internal cycles, then push bank (native only), counter, status downward
// R5 - interrupt entry 7/8 cycles; vector low/high read with vector pull low
// R6 - pull: opcode, two internal, low at stack+1, high at stack+2 if wide
// R7 - pulls restore accumulator, data bank, direct, status, both index registers
// R8 - push: opcode, one internal, high at stack then low at stack-1 if wide
// R9 - pushes save accumulator, data bank, status, direct, program bank, index registers
// R10 - push absolute: two operand reads, high at stack, low below, five cycles
// R11 - push indirect: offset, optional internal, word at direct+offset, pushed high first
// R12 - push relative: 16-bit offset, internal cycle, push counter plus offset
// R13 - outside memory treats cycles with both valid strobes low as side-effect free
`timescale 1ns/1ns
`include "bss_seq_regs.vh"
module bss_seq #(
	parameter CYCLE_DIV = `BSS_CYCLE_DIV
) (
	// clock and reset
	input wire i_ref_clk,
	input wire i_rst_n,
	// command
	input wire i_start,
	input wire [2:0] i_kind,
	input wire [2:0] i_reg_sel,
	input wire i_wide,
	input wire i_emulation,
	input wire i_taken,
	input wire [1:0] i_extra_io,
	output wire o_ready,
	// processor state at command
	input wire [15:0] i_pc,
	input wire [7:0] i_pbr,
	input wire [15:0] i_sp,
	input wire [15:0] i_dp,
	input wire [15:0] i_vector,
	input wire [7:0] i_status,
	input wire [15:0] i_push_word,
	// result
	output reg o_done,
	output reg [15:0] o_next_pc,
	output reg [7:0] o_next_bank,
	output reg [15:0] o_new_sp,
	output reg [15:0] o_word,
	// system bus
	input wire [7:0] i_mem_rdata,
	output reg o_program_address_valid,
	output reg o_data_address_valid,
	output reg o_vector_pull_n,
	output reg o_memory_lock_n,
	output reg o_read_not_write,
	output reg [7:0] o_bank,
	output reg [15:0] o_addr,
	output reg [7:0] o_wdata
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	// ----------------------------------------
	// state
	// ----------------------------------------
	wire tick;
	reg tick_d_r;
	reg [1:0] st_r;
	reg [3:0] step_r;
	reg [2:0] kind_r;
	reg wide_r;
	reg emu_r;
	reg taken_r;
	reg [1:0] opt_r;
	reg [15:0] pc_r;
	reg [7:0] pbr_r;
	reg [15:0] sp_r;
	reg [15:0] dp_r;
	reg [15:0] vec_r;
	reg [7:0] stat_r;
	reg [15:0] word_r;
	reg [15:0] tmp_r;
	reg [7:0] do_r;
	reg [1:0] cap_r;
	reg last_r;

	bss_cycle_div #(.DIV(CYCLE_DIV)) u_div (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.o_tick(tick)
	);

	wire idle = (st_r == ST_IDLE);
	wire run = (st_r == ST_RUN);
	wire take = tick & i_start & idle;
	assign o_ready = idle;

	// ----------------------------------------
	// address arithmetic
	// ----------------------------------------
	wire [15:0] pc1 = pc_r + `BSS_INC1;
	wire [15:0] pc2 = pc_r + `BSS_INC2;
	wire [15:0] pc3 = pc_r + `BSS_INC3;
	wire [15:0] sext = {{8{tmp_r[7]}}, tmp_r[7:0]};
	wire [15:0] per_word = pc3 + tmp_r;
	wire [15:0] dop_addr = dp_r + {8'h00, do_r};
	wire [3:0] io_end = `BSS_STEP_2 + {2'h0, opt_r};
	wire [3:0] rel = step_r - {2'h0, opt_r};
	wire [3:0] nwr = emu_r ? `BSS_HWINT_WR_EMU : `BSS_HWINT_WR_NAT;
	wire [3:0] widx = step_r - `BSS_STEP_3 + {3'h0, emu_r};
	wire sel_wide = (i_reg_sel == `BSS_R_DIR) |
		(i_wide & ((i_reg_sel == `BSS_R_ACC) | (i_reg_sel == `BSS_R_IDX_X) | (i_reg_sel == `BSS_R_IDX_Y)));

	reg [15:0] tgt;
	reg [7:0] tgt_bank;
	reg [15:0] push_src;
	always @* begin
		tgt_bank = pbr_r;
		push_src = tmp_r;
		case (kind_r)
			`BSS_K_BRANCH: tgt = taken_r ? (pc2 + sext) : pc2; // see R2
			`BSS_K_LONG: tgt = pc3 + tmp_r; // see R3
			`BSS_K_HWINT: begin
				tgt = tmp_r; // see R5
				tgt_bank = `BSS_BANK_ZERO;
			end
			`BSS_K_PULL: tgt = pc1;
			`BSS_K_PUSH: begin
				tgt = pc1;
				push_src = word_r;
			end
			`BSS_K_PEI: tgt = pc2;
			`BSS_K_PER: begin
				tgt = pc3;
				push_src = per_word; // see R12
			end
			default: tgt = pc3;
		endcase
	end

	// ----------------------------------------
	// per-cycle decode
	// ----------------------------------------
	reg d_vpa;
	reg d_vda;
	reg d_rnw;
	reg d_vpn;
	reg [7:0] d_bank;
	reg [15:0] d_addr;
	reg [7:0] d_wdata;
	reg [1:0] d_cap;
	reg d_last;
	reg opc;
	reg io;
	reg prg;
	reg stk_rd;
	reg stk_wr;
	reg nextf;

	always @* begin
		opc = 1'b0;
		io = 1'b0;
		prg = 1'b0;
		stk_rd = 1'b0;
		stk_wr = 1'b0;
		nextf = 1'b0;
		d_addr = pc1;
		d_wdata = push_src[7:0];
		d_cap = `BSS_CAP_NONE;
		d_vpn = 1'b1;
		d_bank = pbr_r;
		case (kind_r)
			`BSS_K_BRANCH: begin
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r == `BSS_STEP_2) begin
					prg = 1'b1; // see R1
					d_cap = `BSS_CAP_LO;
				end else if (step_r <= io_end) io = 1'b1; // see R2
				else nextf = 1'b1;
			end
			`BSS_K_LONG: begin
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r == `BSS_STEP_2) begin
					prg = 1'b1; // see R3
					d_cap = `BSS_CAP_LO;
				end else if (step_r == `BSS_STEP_3) begin
					prg = 1'b1;
					d_addr = pc2;
					d_cap = `BSS_CAP_HI;
				end else if (step_r == `BSS_STEP_4) begin
					io = 1'b1;
					d_addr = pc2;
				end else nextf = 1'b1;
			end
			`BSS_K_HWINT: begin
				if (step_r <= `BSS_STEP_2) begin
					io = 1'b1; // see R4
					d_addr = pc_r;
				end else if (step_r <= io_end + nwr - {2'h0, opt_r}) begin
					stk_wr = 1'b1; // see R4
					case (widx)
						4'h0: d_wdata = pbr_r;
						4'h1: d_wdata = pc_r[15:8];
						4'h2: d_wdata = pc_r[7:0];
						default: d_wdata = stat_r;
					endcase
				end else if (step_r <= `BSS_STEP_4 + nwr) begin
					stk_rd = 1'b1; // see R5
					d_vpn = 1'b0;
					d_bank = `BSS_BANK_ZERO;
					d_addr = (step_r == `BSS_STEP_3 + nwr) ? vec_r : vec_r + `BSS_INC1;
					d_cap = (step_r == `BSS_STEP_3 + nwr) ? `BSS_CAP_LO : `BSS_CAP_HI;
				end else nextf = 1'b1;
			end
			`BSS_K_PULL: begin
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r <= `BSS_STEP_3) io = 1'b1; // see R6
				else if (step_r == `BSS_STEP_4 || (step_r == `BSS_STEP_5 && wide_r)) begin
					stk_rd = 1'b1; // see R6, R7
					d_bank = `BSS_BANK_ZERO;
					d_addr = sp_r + `BSS_INC1;
					d_cap = (step_r == `BSS_STEP_4) ? `BSS_CAP_LO : `BSS_CAP_HI;
				end else nextf = 1'b1;
			end
			`BSS_K_PUSH: begin
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r == `BSS_STEP_2) io = 1'b1; // see R8
				else if (step_r == `BSS_STEP_3 || (step_r == `BSS_STEP_4 && wide_r)) begin
					stk_wr = 1'b1; // see R8, R9
					if (step_r == `BSS_STEP_3 && wide_r) d_wdata = push_src[15:8];
				end else nextf = 1'b1;
			end
			`BSS_K_PEI: begin
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r == `BSS_STEP_2) begin
					prg = 1'b1; // see R11
					d_cap = `BSS_CAP_DO;
				end else if (step_r <= io_end) io = 1'b1;
				else if (rel == `BSS_STEP_3 || rel == `BSS_STEP_4) begin
					stk_rd = 1'b1; // see R11
					d_bank = `BSS_BANK_ZERO;
					d_addr = (rel == `BSS_STEP_3) ? dop_addr : dop_addr + `BSS_INC1;
					d_cap = (rel == `BSS_STEP_3) ? `BSS_CAP_LO : `BSS_CAP_HI;
				end else if (rel == `BSS_STEP_5 || rel == `BSS_STEP_6) begin
					stk_wr = 1'b1;
					if (rel == `BSS_STEP_5) d_wdata = push_src[15:8];
				end else nextf = 1'b1;
			end
			default: begin
				// absolute and relative pushes share one shape
				if (step_r == `BSS_STEP_OPC) opc = 1'b1;
				else if (step_r == `BSS_STEP_2) begin
					prg = 1'b1; // see R10, R12
					d_cap = `BSS_CAP_LO;
				end else if (step_r == `BSS_STEP_3) begin
					prg = 1'b1;
					d_addr = pc2;
					d_cap = `BSS_CAP_HI;
				end else if (kind_r == `BSS_K_PER && step_r == `BSS_STEP_4) begin
					io = 1'b1; // see R12
					d_addr = pc2;
				end else if (rel_push_hi(kind_r, step_r) || rel_push_lo(kind_r, step_r)) begin
					stk_wr = 1'b1; // see R10, R12
					if (rel_push_hi(kind_r, step_r)) d_wdata = push_src[15:8];
				end else nextf = 1'b1;
			end
		endcase
		if (opc) d_addr = pc_r;
		if (stk_wr) begin
			d_bank = `BSS_BANK_ZERO;
			d_addr = sp_r;
		end
		if (nextf) begin
			d_bank = tgt_bank;
			d_addr = tgt;
		end
		// internal cycles keep both strobes low so memory sees no access, see R13
		d_vpa = opc | prg | nextf;
		d_vda = opc | stk_rd | stk_wr | nextf;
		d_rnw = ~stk_wr;
		d_last = nextf;
	end

	function rel_push_hi(input [2:0] k, input [3:0] s);
		rel_push_hi = (k == `BSS_K_PER) ? (s == `BSS_STEP_5) : (s == `BSS_STEP_4);
	endfunction

	function rel_push_lo(input [2:0] k, input [3:0] s);
		rel_push_lo = (k == `BSS_K_PER) ? (s == `BSS_STEP_6) : (s == `BSS_STEP_5);
	endfunction

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= ST_IDLE;
			step_r <= `BSS_STEP_NONE;
			kind_r <= `BSS_K_BRANCH;
			wide_r <= 1'b0;
			emu_r <= 1'b0;
			taken_r <= 1'b0;
			opt_r <= 2'h0;
			pc_r <= `BSS_RST_ADDR;
			pbr_r <= `BSS_RST_BYTE;
			sp_r <= `BSS_RST_ADDR;
			dp_r <= `BSS_RST_ADDR;
			vec_r <= `BSS_RST_ADDR;
			stat_r <= `BSS_RST_BYTE;
			word_r <= `BSS_RST_ADDR;
			tmp_r <= `BSS_RST_ADDR;
			do_r <= `BSS_RST_BYTE;
			o_done <= 1'b0;
			o_next_pc <= `BSS_RST_ADDR;
			o_next_bank <= `BSS_RST_BYTE;
			o_new_sp <= `BSS_RST_ADDR;
			o_word <= `BSS_RST_ADDR;
		end else begin
			o_done <= 1'b0;
			if (take) begin
				st_r <= ST_RUN;
				step_r <= `BSS_STEP_OPC;
				kind_r <= i_kind;
				wide_r <= sel_wide; // see R7, R9
				emu_r <= i_emulation;
				taken_r <= i_taken;
				// a third optional cycle is not defined, so the count saturates
				opt_r <= (i_extra_io > `BSS_OPT_MAX) ? `BSS_OPT_MAX : i_extra_io;
				pc_r <= i_pc;
				pbr_r <= i_pbr;
				sp_r <= i_sp;
				dp_r <= i_dp;
				vec_r <= i_vector;
				stat_r <= i_status;
				word_r <= i_push_word;
				tmp_r <= `BSS_RST_ADDR;
			end else if (tick && run) begin
				case (cap_r)
					`BSS_CAP_LO: tmp_r[7:0] <= i_mem_rdata;
					`BSS_CAP_HI: tmp_r[15:8] <= i_mem_rdata;
					`BSS_CAP_DO: do_r <= i_mem_rdata;
					default: tmp_r <= tmp_r;
				endcase
				// writes walk the stack down, pulls walk it up
				if (!o_read_not_write) sp_r <= sp_r - `BSS_INC1; // see R4, R8
				else if (kind_r == `BSS_K_PULL && cap_r != `BSS_CAP_NONE) sp_r <= sp_r + `BSS_INC1; // see R6
				if (last_r) begin
					st_r <= ST_IDLE;
					step_r <= `BSS_STEP_NONE;
					o_done <= 1'b1;
					o_next_pc <= o_addr;
					o_next_bank <= o_bank;
					o_new_sp <= sp_r;
					o_word <= tmp_r;
				end else begin
					step_r <= step_r + `BSS_STEP_OPC;
				end
			end
		end
	end

	// ----------------------------------------
	// bus outputs, reloaded one clock after each cycle boundary
	// ----------------------------------------
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_d_r <= 1'b0;
			cap_r <= `BSS_CAP_NONE;
			last_r <= 1'b0;
			o_program_address_valid <= 1'b0;
			o_data_address_valid <= 1'b0;
			o_vector_pull_n <= 1'b1;
			o_memory_lock_n <= 1'b1;
			o_read_not_write <= 1'b1;
			o_bank <= `BSS_RST_BYTE;
			o_addr <= `BSS_RST_ADDR;
			o_wdata <= `BSS_RST_BYTE;
		end else begin
			tick_d_r <= tick;
			o_memory_lock_n <= 1'b1;
			if (tick_d_r) begin
				o_program_address_valid <= run & d_vpa;
				o_data_address_valid <= run & d_vda;
				o_vector_pull_n <= ~run | d_vpn;
				o_read_not_write <= ~run | d_rnw;
				o_bank <= run ? d_bank : pbr_r;
				o_addr <= run ? d_addr : pc_r;
				o_wdata <= d_wdata;
				cap_r <= run ? d_cap : `BSS_CAP_NONE;
				last_r <= run & d_last;
			end
		end
	end
endmodule // bss_seq

// [tb/bss_seq_props.sv]
// bus-cycle assertions for the branch and stack sequencer
`timescale 1ns/1ns
module bss_seq_props #(
	parameter CYCLE_DIV = 4
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire o_done,
	input wire o_program_address_valid,
	input wire o_data_address_valid,
	input wire o_vector_pull_n,
	input wire o_memory_lock_n,
	input wire o_read_not_write,
	input wire [7:0] o_bank,
	input wire [15:0] o_addr
);
	// the pair sequences assume four clocks per bus cycle, as the bench runs
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_next_up;
		$stable(o_addr) [*3] ##1 (o_addr == $past(o_addr) + 16'h0001);
	endsequence
	sequence s_next_down;
		$stable(o_addr) [*3] ##1 (o_read_not_write || o_addr == $past(o_addr) - 16'h0001);
	endsequence
	a_internal_read: assert property (
		!o_program_address_valid && !o_data_address_valid |-> o_read_not_write && o_vector_pull_n)
		else $error("internal cycle not a plain read");
	a_write_bank_zero: assert property (
		!o_read_not_write |-> o_data_address_valid && !o_program_address_valid && o_bank == 8'h00)
		else $error("stack write off bank zero");
	a_vector_read: assert property (
		!o_vector_pull_n |-> o_data_address_valid && !o_program_address_valid && o_read_not_write && o_bank == 8'h00)
		else $error("vector pull on wrong cycle kind");
	a_vector_pair: assert property (
		$fell(o_vector_pull_n) |=> s_next_up)
		else $error("vector high not read after low");
	a_write_pair: assert property (
		$fell(o_read_not_write) |=> s_next_down)
		else $error("second stack write not one below");
	a_lock_high: assert property (
		o_memory_lock_n)
		else $error("memory lock asserted");
	a_done_pulse: assert property (
		o_done |=> !o_done)
		else $error("done longer than one clock");
	a_done_on_fetch: assert property (
		o_done |-> o_program_address_valid && o_data_address_valid && o_read_not_write)
		else $error("done without opcode fetch on bus");
endmodule // bss_seq_props

// [tb/bss_mem_model.sv]
// memory and peripheral model on the far side of the sequencer bus
`timescale 1ns/1ns
module bss_mem_model (
	input wire i_ref_clk,
	input wire i_program_address_valid,
	input wire i_data_address_valid,
	input wire i_read_not_write,
	input wire [15:0] i_addr,
	input wire [7:0] i_wdata,
	output reg [7:0] o_rdata
);
	// only the low address byte decodes; the bench keeps its regions apart
	reg [7:0] mem [0:255];
	reg [7:0] junk_r;
	integer i;
	initial begin
		junk_r = 8'h00;
		for (i = 0; i < 256; i = i + 1) begin
			mem[i] = i[7:0] ^ 8'ha5;
		end
	end
	always @(posedge i_ref_clk) begin
		junk_r <= junk_r + 8'h3b;
		if (i_data_address_valid && !i_read_not_write) begin
			mem[i_addr[7:0]] <= i_wdata;
		end
	end
	// no strobe: data lines float, so show a moving pattern, never stale data
	always @* begin
		o_rdata = junk_r;
		if (i_program_address_valid || i_data_address_valid) begin
			o_rdata = mem[i_addr[7:0]];
		end
	end
endmodule // bss_mem_model

// [tb/branch_stack_bus_cycle_sequencer_tb.sv]
// self-checking bench for the branch and stack bus-cycle sequencer
`timescale 1ns/1ns
`include "bss_seq_regs.vh"
module branch_stack_bus_cycle_sequencer_tb;
	localparam DIV = 4;
	reg i_ref_clk = 1'b0;
	reg i_rst_n = 1'b0;
	reg start = 1'b0;
	reg [2:0] kind = 3'h0;
	reg [2:0] sel = 3'h0;
	reg wide = 1'b1;
	reg emu = 1'b0;
	reg taken = 1'b0;
	reg [1:0] xio = 2'h0;
	reg [15:0] sp = 16'h0100;
	reg [15:0] pw = 16'h0000;
	reg w16;
	wire ready, done, prog_v, data_v, vec_n, lock_n, rnw;
	wire [15:0] next_pc, new_sp, word, addr;
	wire [7:0] next_bank, bank, wdata, rdata;
	integer error_cnt = 0;
	integer compares = 0;
	integer n;
	integer k;
	always #25 i_ref_clk = ~i_ref_clk;
	bss_seq #(.CYCLE_DIV(DIV)) i_bss_seq (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(start),
		.i_kind(kind), .i_reg_sel(sel), .i_wide(wide), .i_emulation(emu), .i_taken(taken), .i_extra_io(xio),
		.o_ready(ready), .i_pc(16'h1000), .i_pbr(8'h12), .i_sp(sp), .i_dp(16'h0300), .i_vector(16'hfffa),
		.i_status(8'h3c), .i_push_word(pw), .o_done(done), .o_next_pc(next_pc), .o_next_bank(next_bank),
		.o_new_sp(new_sp), .o_word(word), .i_mem_rdata(rdata), .o_program_address_valid(prog_v),
		.o_data_address_valid(data_v), .o_vector_pull_n(vec_n), .o_memory_lock_n(lock_n),
		.o_read_not_write(rnw), .o_bank(bank), .o_addr(addr), .o_wdata(wdata));
	bss_mem_model i_bss_mem_model (.i_ref_clk(i_ref_clk), .i_program_address_valid(prog_v),
		.i_data_address_valid(data_v), .i_read_not_write(rnw), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] m(input [15:0] a);
		m = i_bss_mem_model.mem[a[7:0]];
	endfunction
	task check(input [15:0] got, input [15:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// clocks are counted from the take to the done pulse, DIV per bus cycle plus the next fetch
	task run(input [2:0] kd, input [2:0] rs, input integer cyc);
		@(negedge i_ref_clk);
		kind = kd;
		sel = rs;
		start = 1'b1;
		n = 0;
		while (ready !== 1'b0 && n < 40) begin
			@(negedge i_ref_clk);
			n = n + 1;
		end
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(negedge i_ref_clk);
			n = n + 1;
		end
		check(n[15:0], 16'((cyc + 1) * DIV));
		check({15'h0000, ready}, 16'h0001);
	endtask
	task conclude;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_branch;
		taken = 1'b1;
		xio = 2'h2;
		run(`BSS_K_BRANCH, 3'h0, 4);
		check(next_pc, 16'h0fa6);
		xio = 2'h1;
		run(`BSS_K_BRANCH, 3'h0, 3);
		check(next_pc, 16'h0fa6);
		taken = 1'b0;
		xio = 2'h0;
		run(`BSS_K_BRANCH, 3'h0, 2);
		check(next_pc, 16'h1002);
	endtask
	task t_long;
		run(`BSS_K_LONG, 3'h0, 4);
		check(word, 16'ha7a4);
		check(next_pc, 16'hb7a7);
	endtask
	task t_hwint;
		sp = 16'h01f0;
		run(`BSS_K_HWINT, 3'h0, 8);
		check({m(sp), m(sp - 16'h0001)}, 16'h1210);
		check({m(sp - 16'h0002), m(sp - 16'h0003)}, 16'h003c);
		check(new_sp, 16'h01ec);
		check(next_pc, 16'h5e5f);
		check({8'h00, next_bank}, 16'h0000);
		emu = 1'b1;
		sp = 16'h01e0;
		run(`BSS_K_HWINT, 3'h0, 7);
		check({m(sp), m(sp - 16'h0001)}, 16'h1000);
		check(new_sp, 16'h01dd);
		emu = 1'b0;
	endtask
	task t_pull;
		sp = 16'h0160;
		for (k = 0; k < 6; k = k + 1) begin
			w16 = (k == 0 || k == 2 || k >= 4);
			run(`BSS_K_PULL, k[2:0], w16 ? 5 : 4);
			check(word, w16 ? 16'hc7c4 : 16'h00c4);
			check(new_sp, w16 ? 16'h0162 : 16'h0161);
		end
		wide = 1'b0;
		run(`BSS_K_PULL, `BSS_R_ACC, 4);
		check(word, 16'h00c4);
		check(new_sp, 16'h0161);
		wide = 1'b1;
	endtask
	task t_push;
		for (k = 0; k < 7; k = k + 1) begin
			w16 = (k == 0 || k == 2 || k == 4 || k == 5);
			sp = {8'h01, k[2:0], 5'h00};
			pw = {8'hbe, 5'h00, k[2:0]};
			run(`BSS_K_PUSH, k[2:0], w16 ? 4 : 3);
			check(new_sp, sp - (w16 ? 16'h0002 : 16'h0001));
			if (w16) begin
				check({m(sp), m(sp - 16'h0001)}, pw);
			end else begin
				check({8'h00, m(sp - 16'h0001)}, {8'h00, (sp[7:0] - 8'h01) ^ 8'ha5});
				check({8'h00, m(sp)}, {8'h00, pw[7:0]});
			end
		end
	endtask
	task t_stack_ea;
		sp = 16'h0190;
		run(`BSS_K_PEA, 3'h0, 5);
		check({m(sp), m(sp - 16'h0001)}, 16'ha7a4);
		check(new_sp, 16'h018e);
		check(next_pc, 16'h1003);
		sp = 16'h01a0;
		for (k = 0; k < 2; k = k + 1) begin
			xio = k[1:0];
			run(`BSS_K_PEI, 3'h0, 6 + k);
			check({m(sp), m(sp - 16'h0001)}, 16'h0001);
			check(new_sp, 16'h019e);
		end
		xio = 2'h0;
		sp = 16'h01b0;
		run(`BSS_K_PER, 3'h0, 6);
		check({m(sp), m(sp - 16'h0001)}, 16'hb7a7);
	endtask
	initial begin
		#500000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		t_branch;
		t_long;
		t_hwint;
		t_pull;
		t_push;
		t_stack_ea;
		conclude;
	end
endmodule // branch_stack_bus_cycle_sequencer_tb

bind bss_seq bss_seq_props #(.CYCLE_DIV(CYCLE_DIV)) i_bss_seq_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.o_done(o_done), .o_program_address_valid(o_program_address_valid),
	.o_data_address_valid(o_data_address_valid), .o_vector_pull_n(o_vector_pull_n),
	.o_memory_lock_n(o_memory_lock_n), .o_read_not_write(o_read_not_write), .o_bank(o_bank), .o_addr(o_addr));
